// file: lcd_serpal_cfg.svh
// offsets, field codes and widths for the pixel serializer and palette
`ifndef LCD_SERPAL_CFG_SVH
`define LCD_SERPAL_CFG_SVH

// pixel_depth_field codes
`define DEPTH_1BPP        3'h0
`define DEPTH_2BPP        3'h1
`define DEPTH_4BPP        3'h2
`define DEPTH_8BPP        3'h3
`define DEPTH_16BPP       3'h4
`define DEPTH_24BPP       3'h5

// memory_order_field codes
`define ORDER_LITTLE      1'h0
`define ORDER_BIG         1'h1

// display_type_field codes
`define DISP_TFT          2'h0
`define DISP_STN_MONO     2'h1
`define DISP_STN_COLOUR   2'h2

// datapath widths
`define WORD_W            32
`define PIX_W             24
`define BUF_W             56
`define CNT_W             6
`define LUT_AW            8
`define LUT_DW            16
`define LUT_DEPTH         256
`define FIFO_DEPTH        8

// palette entry field positions
`define ENT_RED_LSB       0
`define ENT_GREEN_LSB     5
`define ENT_BLUE_LSB      10
`define ENT_INT_BIT       15

// panel data lane positions (tft palettized)
`define LANE0_LSB         0
`define LANE1_LSB         8
`define LANE2_LSB         16

`endif

// file: lcd_serpal_pkg.sv
// types shared by the serializer and palette datapath
package lcd_serpal_pkg;
   // one palette entry split into its fields
   typedef struct packed
   {
      logic       intensity;
      logic [4:0] blue;
      logic [4:0] green;
      logic [4:0] red;
   } lut_entry_t;

   typedef logic [31:0] word_t;  // fifo word
   typedef logic [23:0] pixel_t; // widest pixel
   typedef logic [5:0]  count_t; // bit counts in the serializer
endpackage : lcd_serpal_pkg

// file: word_stream_if.sv
// valid/ready word stream into the fifo and from the fifo to the serializer
`timescale 1ns/1ps
interface word_stream_if #(parameter int W = 32);
   logic         valid; // word offered
   logic         ready; // word taken
   logic [W-1:0] data;  // word itself

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : word_stream_if

// file: word_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
)
(
   input wire logic clk,
   input wire logic rst,
   word_stream_if.snk wr,
   word_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];   // storage
   logic [AW-1:0]    wptr_q;          // write slot
   logic [AW-1:0]    rptr_q;          // read slot
   logic [AW:0]      level_q;         // words held
   logic             push;            // accepted write
   logic             pop;             // accepted read

   // honest flags: full refuses writes, empty hides data
   assign wr.ready = (level_q != (AW+1)'(DEPTH));
   assign rd.valid = (level_q != '0);
   assign rd.data  = mem_q[rptr_q];
   assign push     = wr.valid && wr.ready;
   assign pop      = rd.valid && rd.ready;

   // storage write, no reset needed on data
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_q[wptr_q] <= wr.data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wptr_q  <= '0;
         rptr_q  <= '0;
         level_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
         end
         if (pop)
         begin
            rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
         end
         if (push && !pop)
         begin
            level_q <= level_q + 1'b1;
         end
         else if (pop && !push)
         begin
            level_q <= level_q - 1'b1;
         end
      end
   end
endmodule : word_fifo

// file: lcd_serpal.sv
// lcd datapath: word serializer and palette lookup stages
//
// Summary of operation
// R01 - split fifo words into 1..24-bit pixels
// R02 - little or big endian memory order
// R03 - little endian: pixel 0 in low bits
// R04 - big endian: pixel 0 in high bits
// R05 - small pixels index the colour table
// R06 - bypass table for wide or gray pixels
// R07 - 256 entries of 16 bits, host accessible
// R08 - entry in low half, word writes only
// R09 - entry: intensity, blue, green, red fields
// R10 - stn mono uses top four red bits
// R11 - stn colour uses top four bits each
// R12 - tft: intensity is bit 2 of each lane
// R13 - tft palettized: two bits below zero
// R14 - display type selects palette behaviour
// R15 - one pixel or three sub-pixels per step
// R16 - tft colour sits above intensity bit
// R17 - fetch word only when current one spent
`timescale 1ns/1ps
`include "lcd_serpal_cfg.svh"
module lcd_serpal
   import lcd_serpal_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   // configuration fields
   input  wire logic [2:0]  pixel_depth_field,
   input  wire logic        memory_order_field,
   input  wire logic [1:0]  display_type_field,
   input  wire logic        restart,
   // words from the upstream fifo
   input  wire logic        in_valid,
   output logic             in_ready,
   input  wire logic [31:0] in_data,
   // per-pixel output toward dithering and shifter
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic [23:0]      out_data,
   output logic             out_palettized,
   // host port to the colour lookup table
   input  wire logic        lut_wr,
   input  wire logic        lut_rd,
   input  wire logic [7:0]  lut_addr,
   input  wire logic [31:0] lut_wdata,
   output logic [31:0]      lut_rdata,
   output logic             lut_rvalid
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // bits per pixel for a depth code
   function automatic count_t depth_bits(input logic [2:0] code);
      count_t n;
      n = 6'h01;
      case (code)
         `DEPTH_1BPP:  n = 6'h01;
         `DEPTH_2BPP:  n = 6'h02;
         `DEPTH_4BPP:  n = 6'h04;
         `DEPTH_8BPP:  n = 6'h08;
         `DEPTH_16BPP: n = 6'h10;
         `DEPTH_24BPP: n = 6'h18;
         default:      n = 6'h01;
      endcase
      return n;
   endfunction : depth_bits

   // keep only the low n bits of a pixel
   function automatic pixel_t keep_low(input pixel_t v, input count_t n);
      pixel_t m;
      m = 24'hffffff;
      if (n < 6'h18)
      begin
         m = ~(24'hffffff << n);
      end
      return v & m;
   endfunction : keep_low

   // whether a type and depth go through the table
   function automatic logic uses_table(input logic [1:0] dt, input logic [2:0] dc);
      logic p;
      p = 1'b0;
      case (dt)
         `DISP_TFT:        p = (dc <= `DEPTH_8BPP);
         `DISP_STN_MONO:   p = (dc <= `DEPTH_2BPP);
         `DISP_STN_COLOUR: p = (dc <= `DEPTH_8BPP);
         default:          p = 1'b0;
      endcase
      return p;
   endfunction : uses_table

   ////////////////////////////////////////////////////////////////////////////
   // input buffering

   word_stream_if #(.W(`WORD_W)) fill_if ();   // upstream into fifo
   word_stream_if #(.W(`WORD_W)) drain_if ();  // fifo into serializer

   assign fill_if.valid = in_valid;
   assign fill_if.data  = in_data;
   assign in_ready      = fill_if.ready;       // back-pressure upstream

   // eight words of slack between the dma side and pixel pace
   word_fifo #(
      .WIDTH (`WORD_W),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clk (clk),
      .rst (rst),
      .wr  (fill_if.snk),
      .rd  (drain_if.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // pipeline advance

   logic    s1_v_q;    // serialized pixel held
   pixel_t  s1_pix_q;  // serialized pixel value
   logic    s2_v_q;    // looked-up pixel held
   pixel_t  s2_raw_q;  // raw pixel alongside lookup
   logic    s2_pal_q;  // pixel went through table
   logic    s3_v_q;    // formatted pixel held
   logic    adv;       // whole pipe moves

   // stages move together; a stalled output freezes all of them
   assign adv = !s3_v_q || out_ready;

   ////////////////////////////////////////////////////////////////////////////
   // serializer

   logic [`BUF_W-1:0] buf_q;     // unconsumed bits
   count_t            cnt_q;     // number of valid bits in buf_q
   count_t            width;     // current pixel width
   logic              need_word; // not enough bits for a pixel
   logic              load;      // word taken this cycle
   logic              emit;      // pixel leaves this cycle
   pixel_t            pix_now;   // pixel at the buffer head

   assign width = depth_bits(pixel_depth_field);
   // R17 fetch when spent
   assign need_word      = (cnt_q < width);
   assign drain_if.ready = need_word;
   assign load           = need_word && drain_if.valid;
   // R17 stall while empty
   assign emit           = !need_word && adv;

   // head pixel in either memory order
   always_comb
   begin
      pix_now = '0;
      if (memory_order_field == `ORDER_LITTLE)
      begin
         // R03 lowest bits first
         pix_now = keep_low(buf_q[`PIX_W-1:0], width);
      end
      else
      begin
         // R04 highest bits first
         pix_now = keep_low(buf_q[`BUF_W-1 -: `PIX_W] >> (6'h18 - width), width);
      end
   end

   // bit buffer; 24-bit pixels straddle words, so leftovers are kept
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         buf_q <= '0;
         cnt_q <= '0;
      end
      else if (restart)
      begin
         // drop partial data at a frame boundary
         buf_q <= '0;
         cnt_q <= '0;
      end
      // R02 order chooses side
      else if (load)
      begin
         if (memory_order_field == `ORDER_LITTLE)
         begin
            // R03 append above leftovers
            buf_q <= buf_q | (`BUF_W'({24'h0, drain_if.data}) << cnt_q);
         end
         else
         begin
            // R04 append below leftovers
            buf_q <= buf_q | ({drain_if.data, 24'h0} >> cnt_q);
         end
         cnt_q <= cnt_q + 6'h20;
      end
      else if (emit)
      begin
         // R01 consume one pixel
         if (memory_order_field == `ORDER_LITTLE)
         begin
            buf_q <= buf_q >> width;
         end
         else
         begin
            buf_q <= buf_q << width;
         end
         cnt_q <= cnt_q - width;
      end
   end

   // stage 1: serialized pixel
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_v_q   <= 1'b0;
         s1_pix_q <= '0;
      end
      else if (restart)
      begin
         s1_v_q <= 1'b0;
      end
      else if (adv)
      begin
         // R15 one pixel per step
         s1_v_q <= emit;
         if (emit)
         begin
            s1_pix_q <= pix_now;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // colour lookup table

   logic [`LUT_DW-1:0] lut_mem [`LUT_DEPTH];  // palette storage
   lut_entry_t         s2_ent_q;              // entry read for the pixel
   logic [15:0]        host_rd_q;             // entry read for the host
   logic               host_rv_q;             // host read answer

   // host writes; only the low half of the word is kept
   always_ff @(posedge clk)
   begin
      // R07 host writes entry
      if (lut_wr)
      begin
         // R08 low half only
         lut_mem[lut_addr] <= lut_wdata[`LUT_DW-1:0];
      end
   end

   // host read back, registered
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         host_rd_q <= '0;
         host_rv_q <= 1'b0;
      end
      else
      begin
         host_rv_q <= lut_rd;
         // R07 host reads entry
         if (lut_rd)
         begin
            host_rd_q <= lut_mem[lut_addr];
         end
      end
   end

   // R08 upper half reads zero
   assign lut_rdata  = {16'h0, host_rd_q};
   assign lut_rvalid = host_rv_q;

   // stage 2: table read for the pixel index
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s2_v_q   <= 1'b0;
         s2_raw_q <= '0;
         s2_pal_q <= 1'b0;
         s2_ent_q <= '0;
      end
      else if (restart)
      begin
         s2_v_q <= 1'b0;
      end
      else if (adv)
      begin
         s2_v_q   <= s1_v_q;
         s2_raw_q <= s1_pix_q;
         // R06 bypass decision
         s2_pal_q <= uses_table(display_type_field, pixel_depth_field);
         // R05 index the table
         s2_ent_q <= lut_entry_t'(lut_mem[s1_pix_q[`LUT_AW-1:0]]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output formatting

   lut_entry_t src_ent;   // entry used for colour
   pixel_t     fmt;       // formatted lanes

   // wide stn colour pixels share the entry layout
   // R09 entry field layout
   assign src_ent = s2_pal_q ? s2_ent_q : lut_entry_t'(s2_raw_q[15:0]);

   // R14 type picks format
   always_comb
   begin
      fmt = '0;
      case (display_type_field)
         `DISP_TFT:
         begin
            if (s2_pal_q)
            begin
               // R16 five colour bits
               fmt[`LANE0_LSB+3 +: 5] = src_ent.red;
               fmt[`LANE1_LSB+3 +: 5] = src_ent.green;
               fmt[`LANE2_LSB+3 +: 5] = src_ent.blue;
               // R12 intensity in each lane
               fmt[`LANE0_LSB+2] = src_ent.intensity;
               fmt[`LANE1_LSB+2] = src_ent.intensity;
               fmt[`LANE2_LSB+2] = src_ent.intensity;
               // R13 low bits stay zero
               fmt[`LANE0_LSB +: 2] = 2'h0;
               fmt[`LANE1_LSB +: 2] = 2'h0;
               fmt[`LANE2_LSB +: 2] = 2'h0;
            end
            else
            begin
               // R06 direct colour passes through
               fmt = s2_raw_q;
            end
         end
         `DISP_STN_MONO:
         begin
            if (s2_pal_q)
            begin
               // R10 gray from red
               fmt[3:0] = src_ent.red[4:1];
            end
            else
            begin
               // R06 4-bit gray direct
               fmt[3:0] = s2_raw_q[3:0];
            end
         end
         `DISP_STN_COLOUR:
         begin
            // R11 four bits each
            // R15 three sub-pixels together
            fmt[3:0]  = src_ent.red[4:1];
            fmt[7:4]  = src_ent.green[4:1];
            fmt[11:8] = src_ent.blue[4:1];
         end
         default:
         begin
            // unused type code gives a blank pixel
            fmt = '0;
         end
      endcase
   end

   // stage 3: registered output toward dithering
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s3_v_q         <= 1'b0;
         out_data       <= '0;
         out_palettized <= 1'b0;
      end
      else if (restart)
      begin
         s3_v_q <= 1'b0;
      end
      else if (adv)
      begin
         s3_v_q <= s2_v_q;
         if (s2_v_q)
         begin
            out_data       <= fmt;
            out_palettized <= s2_pal_q;
         end
      end
   end

   assign out_valid = s3_v_q;

endmodule : lcd_serpal

// file: lcd_serpal_chk.sv
// concurrent checks on the serializer and palette top ports
`timescale 1ns/1ps
`include "lcd_serpal_cfg.svh"
module lcd_serpal_chk
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [2:0]  pixel_depth_field,
   input wire logic        memory_order_field,
   input wire logic [1:0]  display_type_field,
   input wire logic        restart,
   input wire logic        in_valid,
   input wire logic        in_ready,
   input wire logic [31:0] in_data,
   input wire logic        out_valid,
   input wire logic        out_ready,
   input wire logic [23:0] out_data,
   input wire logic        out_palettized,
   input wire logic        lut_wr,
   input wire logic        lut_rd,
   input wire logic [7:0]  lut_addr,
   input wire logic [31:0] lut_wdata,
   input wire logic [31:0] lut_rdata,
   input wire logic        lut_rvalid
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [15:0] shadow_q [256]; // copy of host writes
   logic [7:0]  raddr_q;        // index of last read
   // table mode per type and depth; blank type excluded
   wire pal_w = display_type_field == `DISP_STN_MONO ? pixel_depth_field <= 3'h1
      : pixel_depth_field <= 3'h3;
   // shadow not reset: entries are unknown until written
   always_ff @(posedge clk)
      if (lut_wr)
         shadow_q[lut_addr] <= lut_wdata[15:0];
   // remember read index for the answer cycle
   always_ff @(posedge clk or posedge rst)
      if (rst)
         raddr_q <= 8'h0;
      else if (lut_rd)
         raddr_q <= lut_addr;
   a_reset_quiet: assert property ($fell(rst) |-> !out_valid && !lut_rvalid && in_ready)
      else $error("outputs busy after reset");
   a_read_pulse: assert property (lut_rd |=> lut_rvalid)
      else $error("read gave no answer");
   a_read_only: assert property (lut_rvalid |-> $past(lut_rd))
      else $error("answer without read");
   a_read_back: assert property (lut_rvalid |-> lut_rdata == {16'h0, shadow_q[raddr_q]})
      else $error("read data differs from written entry");
   a_stall_hold: assert property (out_valid && !out_ready && !restart |=>
      out_valid && $stable(out_data) && $stable(out_palettized))
      else $error("pixel changed while stalled");
   a_pal_mode: assert property (out_valid && display_type_field != 2'h3 |->
      out_palettized == pal_w)
      else $error("wrong table use for mode");
   a_tft_zero: assert property (out_valid && out_palettized && display_type_field == `DISP_TFT
      |-> (out_data & 24'h030303) == 24'h0)
      else $error("tft low bits not zero");
   a_tft_int: assert property (out_valid && out_palettized && display_type_field == `DISP_TFT
      |-> out_data[2] == out_data[10] && out_data[10] == out_data[18])
      else $error("intensity differs across lanes");
   a_mono_gray: assert property (out_valid && display_type_field == `DISP_STN_MONO
      |-> out_data[23:4] == 20'h0)
      else $error("mono pixel wider than four bits");
   a_colour_12: assert property (out_valid && display_type_field == `DISP_STN_COLOUR
      |-> out_data[23:12] == 12'h0)
      else $error("colour pixel wider than twelve bits");
   cover property (lut_rvalid);
   cover property (out_valid && !out_ready);
   cover property (out_valid && out_palettized && display_type_field == `DISP_STN_COLOUR);
endmodule : lcd_serpal_chk
bind lcd_serpal lcd_serpal_chk chk (.clk, .rst, .pixel_depth_field, .memory_order_field,
   .display_type_field, .restart, .in_valid, .in_ready, .in_data, .out_valid, .out_ready,
   .out_data, .out_palettized, .lut_wr, .lut_rd, .lut_addr, .lut_wdata, .lut_rdata,
   .lut_rvalid);

// file: word_src.sv
// upstream word source standing in for the dma-fed fifo
`timescale 1ns/1ps
module word_src
   import lcd_serpal_pkg::*;
(
   input  wire logic clk,
   input  wire logic ready,
   output word_t     data,
   output logic      valid
);
   // idle at time zero
   initial
   begin
      valid = 1'b0;
      data = 32'h0;
   end
   // offer one word after gap idle cycles
   task automatic push(input word_t w, input int gap);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      valid <= 1'b1;
      data <= w;
      do @(posedge clk); while (ready !== 1'b1);
      valid <= 1'b0;
      data <= ~w; // released bus must not look valid
   endtask : push
endmodule : word_src

// file: lcd_pixel_serializer_palette_tb.sv
// self-checking bench for the serializer and palette datapath
`timescale 1ns/1ps
`include "lcd_serpal_cfg.svh"
module lcd_pixel_serializer_palette_tb
   import lcd_serpal_pkg::*;
;
   typedef struct {logic [2:0] d; logic o; logic [1:0] t; word_t w; pixel_t p0, p1;} row_t;
   localparam word_t w0 = 32'h8765_4321; // test word
   localparam word_t w1 = 32'hfedc_ba98; // follow-on word
   logic clk = 1'b0, rst = 1'b1, restart = 1'b0, out_ready = 1'b1;
   logic [2:0] pixel_depth_field = 3'h0;
   logic memory_order_field = 1'b0;
   logic [1:0] display_type_field = 2'h0;
   logic lut_wr = 1'b0, lut_rd = 1'b0, in_valid, in_ready, out_valid, out_palettized;
   logic lut_rvalid;
   logic [7:0] lut_addr = 8'h0;
   word_t in_data, lut_rdata, lut_wdata = 32'h0;
   pixel_t out_data;
   int miscompares = 0, n_tests = 0;
   logic [7:0] ra [3] = '{8'h00, 8'h7f, 8'hff}; // read-back addresses
   // ordinary cases: config, word, first two raw pixels
   row_t rows [12] = '{
      '{`DEPTH_1BPP, `ORDER_LITTLE, `DISP_TFT, w0, 24'h1, 24'h0},
      '{`DEPTH_1BPP, `ORDER_BIG, `DISP_TFT, w0, 24'h1, 24'h0},
      '{`DEPTH_2BPP, `ORDER_LITTLE, `DISP_STN_MONO, w0, 24'h1, 24'h0},
      '{`DEPTH_2BPP, `ORDER_BIG, `DISP_STN_MONO, w0, 24'h2, 24'h0},
      '{`DEPTH_4BPP, `ORDER_LITTLE, `DISP_STN_COLOUR, w0, 24'h1, 24'h2},
      '{`DEPTH_4BPP, `ORDER_LITTLE, `DISP_STN_MONO, w0, 24'h1, 24'h2},
      '{`DEPTH_4BPP, `ORDER_BIG, `DISP_TFT, w0, 24'h8, 24'h7},
      '{`DEPTH_8BPP, `ORDER_BIG, `DISP_TFT, w0, 24'h87, 24'h65},
      '{`DEPTH_8BPP, `ORDER_LITTLE, `DISP_STN_COLOUR, w0, 24'h21, 24'h43},
      '{`DEPTH_16BPP, `ORDER_LITTLE, `DISP_TFT, w0, 24'h4321, 24'h8765},
      '{`DEPTH_16BPP, `ORDER_BIG, `DISP_STN_COLOUR, w0, 24'h8765, 24'h4321},
      '{`DEPTH_16BPP, `ORDER_LITTLE, 2'h3, w0, 24'h4321, 24'h8765}};
   ////////////////////////////////////////////////////////////////////////////////
   always #2.5 clk = ~clk; // 200 mhz
   lcd_serpal dut (.clk, .rst, .pixel_depth_field, .memory_order_field, .display_type_field,
      .restart, .in_valid, .in_ready, .in_data, .out_valid, .out_ready, .out_data,
      .out_palettized, .lut_wr, .lut_rd, .lut_addr, .lut_wdata, .lut_rdata, .lut_rvalid);
   word_src src (.clk, .ready(in_ready), .data(in_data), .valid(in_valid));
   ////////////////////////////////////////////////////////////////////////////////
   // table contents chosen by the bench
   function automatic logic [15:0] ent(input logic [7:0] i);
      return {i, ~i};
   endfunction : ent
   // whether a mode goes through the table
   function automatic logic pal(input logic [1:0] t, input logic [2:0] d);
      return d <= 3'h3 && (t != `DISP_STN_MONO || d <= 3'h1);
   endfunction : pal
   // expected panel pixel from raw pixel
   function automatic pixel_t fmt(input logic [1:0] t, input logic p, input pixel_t x);
      lut_entry_t e;
      e = p ? ent(x[7:0]) : x[15:0];
      // unused type code blanks the pixel
      if (t == 2'h3)
         return 24'h0;
      if (t == `DISP_TFT)
         return p ? {e.blue, e.intensity, 2'h0, e.green, e.intensity, 2'h0,
            e.red, e.intensity, 2'h0} : x;
      if (t == `DISP_STN_MONO)
         return {20'h0, p ? e.red[4:1] : x[3:0]};
      return {12'h0, e.blue[4:1], e.green[4:1], e.red[4:1]};
   endfunction : fmt
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test;
      if (miscompares == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   // host accesses, one strobe cycle each
   task automatic lut_write(input logic [7:0] a, input word_t v);
      @(posedge clk);
      lut_wr <= 1'b1;
      lut_addr <= a;
      lut_wdata <= v;
      @(posedge clk);
      lut_wr <= 1'b0;
   endtask : lut_write
   task automatic lut_read(input logic [7:0] a);
      @(posedge clk);
      lut_rd <= 1'b1;
      lut_addr <= a;
      @(posedge clk);
      lut_rd <= 1'b0;
      #1;
      chk(lut_rvalid, 1'b1);
      chk(lut_rdata, {16'h0, ent(a)});
   endtask : lut_read
   // flush under the old mode, then switch while the pipe is empty
   task automatic cfg(input logic [2:0] d, input logic o, input logic [1:0] t);
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      pixel_depth_field <= d;
      memory_order_field <= o;
      display_type_field <= t;
      repeat (2) @(posedge clk);
   endtask : cfg
   // take one pixel, bounded wait, and compare
   task automatic px(input logic [1:0] t, input logic [2:0] d, input pixel_t raw);
      int n;
      n = 0;
      @(negedge clk);
      while (out_valid !== 1'b1 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      chk(out_valid, 1'b1);
      chk(out_data, fmt(t, pal(t, d), raw));
      chk(out_palettized, pal(t, d));
      @(posedge clk);
   endtask : px
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      // upper half set to show it is ignored
      for (int i = 0; i < 256; i++)
         lut_write(8'(i), {16'hffff, ent(8'(i))});
      foreach (ra[i])
         lut_read(ra[i]);
      foreach (rows[i])
      begin
         cfg(rows[i].d, rows[i].o, rows[i].t);
         src.push(rows[i].w, i % 3);
         px(rows[i].t, rows[i].d, rows[i].p0);
         px(rows[i].t, rows[i].d, rows[i].p1);
      end
      // 24-bit pixels spanning two words, second word late
      for (int o = 0; o < 2; o++)
      begin
         cfg(`DEPTH_24BPP, o[0], `DISP_TFT);
         fork
            begin
               src.push(w0, 0);
               src.push(w1, 3);
            end
         join_none
         px(`DISP_TFT, `DEPTH_24BPP, o ? 24'h876543 : 24'h654321);
         px(`DISP_TFT, `DEPTH_24BPP, o ? 24'h21fedc : 24'hba9887);
      end
      // stall downstream until the buffer refuses, then drain in order
      cfg(`DEPTH_16BPP, `ORDER_LITTLE, `DISP_TFT);
      out_ready <= 1'b0;
      fork
         for (int k = 0; k < 12; k++)
            src.push({16'(2 * k + 1), 16'(2 * k)}, 0);
      join_none
      repeat (60) @(posedge clk);
      #1;
      chk(in_ready, 1'b0);
      @(posedge clk);
      out_ready <= 1'b1;
      for (int k = 0; k < 24; k++)
         px(`DISP_TFT, `DEPTH_16BPP, 24'(k));
      // second reset mid-run, then a bypassed mono word
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      cfg(`DEPTH_8BPP, `ORDER_LITTLE, `DISP_STN_MONO);
      src.push(w0, 0);
      px(`DISP_STN_MONO, `DEPTH_8BPP, 24'h21);
      end_of_test();
   end
   // watchdog: the run needs under 1000 cycles, allow twenty times that
   initial
   begin
      #100us;
      miscompares++;
      end_of_test();
   end
endmodule : lcd_pixel_serializer_palette_tb
